// *** common/smcg_pkg.sv ***
package smcg_pkg;
    // ********************************************************
    // Sleep select codes
    // ********************************************************
    localparam logic [2:0] SMCG_SEL_IDLE = 3'h0;
    localparam logic [2:0] SMCG_SEL_ADCQ = 3'h1;
    localparam logic [2:0] SMCG_SEL_PDOWN = 3'h2;
    localparam logic [2:0] SMCG_SEL_PSAVE = 3'h3;
    localparam logic [2:0] SMCG_SEL_RSV4 = 3'h4;
    localparam logic [2:0] SMCG_SEL_RSV5 = 3'h5;
    localparam logic [2:0] SMCG_SEL_STBY = 3'h6;
    localparam logic [2:0] SMCG_SEL_XSTBY = 3'h7;

    // ********************************************************
    // Timing
    // ********************************************************
    localparam int SMCG_IRQ_HOLD_CYC = 4;
    localparam int SMCG_STBY_WAKE_CYC = 6;
    localparam int SMCG_CNT_W = 16;

    // ********************************************************
    // Reset values
    // ********************************************************
    localparam logic SMCG_ASLEEP_RST = 1'b0;

    typedef enum logic [2:0] {
        SMCG_ST_RUN,
        SMCG_ST_SLEEP,
        SMCG_ST_STARTUP,
        SMCG_ST_HOLD
    } smcg_state_t;
endpackage

// *** rtl/smcg_wake_count.sv ***
`timescale 1ns/1ps
// Down counter that raises done in the cycle it reaches zero
module smcg_wake_count
    import smcg_pkg::*;
#(
    parameter int W = SMCG_CNT_W
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic load_i,
    input wire logic [W-1:0] value_i,
    output logic busy_o,
    output logic done_o
);
    logic [W-1:0] cnt_r;
    logic busy_r;

    initial begin
        if (W < 3) $error("smcg_wake_count: W too small");
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r <= '0;
            busy_r <= 1'b0;
        end else if (load_i) begin
            cnt_r <= value_i;
            busy_r <= 1'b1;
        end else if (busy_r) begin
            if (cnt_r == '0) begin
                busy_r <= 1'b0;
            end else begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end

    assign busy_o = busy_r;
    assign done_o = busy_r && (cnt_r == '0);
endmodule // smcg_wake_count

// *** rtl/smcg_periph_gate.sv ***
`timescale 1ns/1ps
// Per-peripheral power reduction gating
module smcg_periph_gate
    import smcg_pkg::*;
#(
    parameter int N = 8
) (
    input wire logic [N-1:0] reduce_i,
    input wire logic [N-1:0] clk_en_i,
    input wire logic [N-1:0] sel_i,
    output logic [N-1:0] clk_en_o,
    output logic [N-1:0] reg_acc_en_o,
    output logic [N-1:0] pins_keep_o
);
    initial begin
        if (N < 1) $error("smcg_periph_gate: N must be positive");
    end

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_per
            // Gating the clock alone freezes state, so clearing the bit resumes it
            assign clk_en_o[g] = clk_en_i[g] & ~reduce_i[g];
            assign reg_acc_en_o[g] = sel_i[g] & ~reduce_i[g];
            // Pin ownership is untouched by gating
            assign pins_keep_o[g] = reduce_i[g];
        end
    endgenerate
endmodule // smcg_periph_gate

// *** rtl/smcg_sleep_ctrl.sv ***
`timescale 1ns/1ps
// How it works
// - Interrupt wake holds the core four cycles beyond start-up, then resumes.
// - Code 000 idle halts only core and flash clocks.
// - Code 001 ADC quiet stops I/O, core, flash; ADC and async run.
// - Entering ADC quiet with ADC enabled starts a conversion.
// - ADC quiet wake set: ADC done, resets, watchdog, TWI, timer2, SPM, levels, pin change.
// - Code 010 power-down stops crystal if selected and all generated clocks.
// - Power-down wakes on resets, TWI match, external irqs, pin change, symbol counter.
// - Power-down wake waits the fuse-selected start-up delay.
// - Code 011 power-save is power-down with timer2 still counting.
// - Power-save timer2 wake needs its mask bit and global enable.
// - Power-save stops the unused timer2 clock; sync clock feeds only timer2.
// - Code 110 with radio crystal is standby: oscillator runs, six-cycle wake.
// - Code 111 with radio crystal is extended standby: power-save plus oscillator, six cycles.
// - Power reduction bit stops the clock and blocks register access.
// - Gated peripheral keeps its pins claimed.
// - Clearing reduction restores prior state; SRAM is the exception.
// - Radio power reduction bit holds the transceiver in reset.
// - An enabled ADC stays enabled in every sleep mode.
// - Comparator off outside idle and ADC quiet unless it uses the internal reference.
// - Internal reference on only when brown-out, comparator or ADC needs it.
// - Fuse-enabled brown-out detector is off in deep sleep.
// - An enabled watchdog keeps running in every sleep mode.
// - With I/O and ADC clocks stopped, input buffers off except wake pins.
// - Digital input disable bits turn a pin buffer off.
module smcg_sleep_ctrl
    import smcg_pkg::*;
#(
    parameter int NPER = 8,
    parameter int NPIN = 16,
    parameter int CNT_W = SMCG_CNT_W
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Core handshake
    input wire logic sleep_arm_bit_i,
    input wire logic [2:0] sleep_select_field_i,
    input wire logic sleep_instr_i,
    input wire logic radio_xosc_sel_i,
    input wire logic [CNT_W-1:0] clock_source_fuses_delay_i,
    input wire logic core_status_word_gie_i,
    // Wake events
    input wire logic ext_reset_i,
    input wire logic wdt_reset_i,
    input wire logic wdt_irq_i,
    input wire logic bod_reset_i,
    input wire logic adc_done_irq_i,
    input wire logic twi_irq_i,
    input wire logic twi_addr_match_i,
    input wire logic timer2_irq_i,
    input wire logic [1:0] timer2_irq_mask_i,
    input wire logic [1:0] timer2_event_i,
    input wire logic spm_ee_ready_irq_i,
    input wire logic [3:0] upper_ext_irqs_i,
    input wire logic upper_ext_level_i,
    input wire logic [3:0] lower_ext_irqs_i,
    input wire logic pin_change_irq_i,
    input wire logic symcnt_irq_i,
    // Peripheral configuration
    input wire logic timer2_en_i,
    input wire logic timer2_async_i,
    input wire logic adc_en_i,
    input wire logic ac_en_i,
    input wire logic ac_uses_ref_i,
    input wire logic brownout_level_fuses_en_i,
    input wire logic deep_sleep_i,
    input wire logic wdt_en_i,
    input wire logic [NPER-1:0] power_reduction_bits_i,
    input wire logic [NPER-1:0] periph_sel_i,
    input wire logic radio_reduce_i,
    input wire logic [NPIN-1:0] analog_pin_buffer_off_lo_i,
    input wire logic [NPIN-1:0] analog_pin_buffer_off_hi_i,
    input wire logic [NPIN-1:0] wake_pin_mask_i,
    // Outputs
    output logic core_run_o,
    output logic clk_cpu_en_o,
    output logic clk_flash_en_o,
    output logic clk_io_en_o,
    output logic clk_adc_en_o,
    output logic clk_asy_en_o,
    output logic main_osc_en_o,
    output logic timer_osc_en_o,
    output logic sync_clk_timer2_only_o,
    output logic adc_start_o,
    output logic adc_keep_en_o,
    output logic ac_en_o,
    output logic vref_en_o,
    output logic bod_en_o,
    output logic wdt_run_o,
    output logic [NPIN-1:0] lo_buf_en_o,
    output logic [NPIN-1:0] hi_buf_en_o,
    output logic [NPER-1:0] periph_clk_en_o,
    output logic [NPER-1:0] periph_reg_acc_en_o,
    output logic [NPER-1:0] periph_pins_keep_o,
    output logic radio_rst_o,
    output logic reset_wake_o,
    output logic asleep_o
);
    // ********************************************************
    // Parameter checks
    // ********************************************************
    initial begin
        if (NPER < 1 || NPIN < 1) $error("smcg_sleep_ctrl: bad widths");
        if (CNT_W < 4) $error("smcg_sleep_ctrl: CNT_W too small");
    end

    // ********************************************************
    // Mode decode
    // ********************************************************
    smcg_state_t state_r;
    logic [2:0] mode_r;
    logic irq_wake_r;
    logic m_idle, m_adcq, m_pdown, m_psave, m_stby, m_xstby, deep;
    logic sel_legal;
    logic wake_irq, wake_rst, wake_any;
    logic cnt_load, cnt_done, cnt_busy;
    logic [CNT_W-1:0] cnt_val;
    logic [CNT_W-1:0] cnt_val_nxt;
    logic t2_wake;
    logic sleeping;

    assign sleeping = (state_r == SMCG_ST_SLEEP);
    assign m_idle = sleeping && mode_r == SMCG_SEL_IDLE;
    assign m_adcq = sleeping && mode_r == SMCG_SEL_ADCQ;
    assign m_pdown = sleeping && mode_r == SMCG_SEL_PDOWN;
    assign m_psave = sleeping && mode_r == SMCG_SEL_PSAVE;
    assign m_stby = sleeping && mode_r == SMCG_SEL_STBY;
    assign m_xstby = sleeping && mode_r == SMCG_SEL_XSTBY;
    assign deep = m_pdown | m_psave | m_stby | m_xstby;

    // Standby codes need the radio crystal; reserved codes never sleep
    always_comb begin
        unique case (sleep_select_field_i)
            SMCG_SEL_RSV4, SMCG_SEL_RSV5: sel_legal = 1'b0;
            SMCG_SEL_STBY, SMCG_SEL_XSTBY: sel_legal = radio_xosc_sel_i;
            default: sel_legal = 1'b1;
        endcase
    end

    // ********************************************************
    // Wake qualification
    // ********************************************************
    assign wake_rst = ext_reset_i | wdt_reset_i | bod_reset_i;
    assign t2_wake = core_status_word_gie_i && |(timer2_irq_mask_i & timer2_event_i);

    always_comb begin
        wake_irq = 1'b0;
        if (m_idle) begin
            wake_irq = adc_done_irq_i | twi_irq_i | timer2_irq_i | spm_ee_ready_irq_i | wdt_irq_i
                     | (|upper_ext_irqs_i) | (|lower_ext_irqs_i) | pin_change_irq_i | symcnt_irq_i;
        end else if (m_adcq) begin
            wake_irq = adc_done_irq_i | wdt_irq_i | twi_irq_i | timer2_irq_i | spm_ee_ready_irq_i
                     | ((|upper_ext_irqs_i) & upper_ext_level_i) | pin_change_irq_i;
        end else if (deep) begin
            wake_irq = twi_addr_match_i | wdt_irq_i | ((|upper_ext_irqs_i) & upper_ext_level_i)
                     | (|lower_ext_irqs_i) | pin_change_irq_i | symcnt_irq_i;
            if ((m_psave | m_xstby) && timer2_en_i) begin
                wake_irq = wake_irq | t2_wake;
            end
        end
    end

    assign wake_any = sleeping && (wake_irq | wake_rst);

    // Standby variants keep the oscillator, so the short restart applies
    always_comb begin
        if (m_stby | m_xstby) begin
            cnt_val_nxt = CNT_W'(SMCG_STBY_WAKE_CYC - 1);
        end else if (m_pdown | m_psave) begin
            cnt_val_nxt = clock_source_fuses_delay_i;
        end else begin
            cnt_val_nxt = '0;
        end
    end

    // ********************************************************
    // Sleep sequencer
    // ********************************************************
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= SMCG_ST_RUN;
            mode_r <= SMCG_SEL_IDLE;
            irq_wake_r <= 1'b0;
            cnt_val <= '0;
        end else begin
            unique case (state_r)
                SMCG_ST_RUN: begin
                    if (sleep_instr_i && sleep_arm_bit_i && sel_legal) begin
                        state_r <= SMCG_ST_SLEEP;
                        mode_r <= sleep_select_field_i;
                    end
                end
                SMCG_ST_SLEEP: begin
                    if (wake_any) begin
                        state_r <= SMCG_ST_STARTUP;
                        irq_wake_r <= ~wake_rst;
                        cnt_val <= cnt_val_nxt;
                    end
                end
                SMCG_ST_STARTUP: begin
                    if (cnt_done) begin
                        state_r <= irq_wake_r ? SMCG_ST_HOLD : SMCG_ST_RUN;
                        // One hold cycle is spent loading the counter
                        cnt_val <= CNT_W'(SMCG_IRQ_HOLD_CYC - 2);
                    end
                end
                SMCG_ST_HOLD: begin
                    if (cnt_done) begin
                        state_r <= SMCG_ST_RUN;
                    end
                end
                default: state_r <= SMCG_ST_RUN;
            endcase
        end
    end

    // Load on entry to each timed state
    logic timed_entry_r;
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            timed_entry_r <= 1'b0;
        end else begin
            timed_entry_r <= (sleeping && wake_any) || (state_r == SMCG_ST_STARTUP && cnt_done && irq_wake_r);
        end
    end
    assign cnt_load = timed_entry_r;

    smcg_wake_count #(.W(CNT_W)) u_cnt (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .load_i(cnt_load),
        .value_i(cnt_val),
        .busy_o(cnt_busy),
        .done_o(cnt_done)
    );

    // ********************************************************
    // Clock domain enables
    // ********************************************************
    // Registered so the gates never glitch on decode
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            clk_cpu_en_o <= 1'b1;
            clk_flash_en_o <= 1'b1;
            clk_io_en_o <= 1'b1;
            clk_adc_en_o <= 1'b1;
            clk_asy_en_o <= 1'b1;
            main_osc_en_o <= 1'b1;
            timer_osc_en_o <= 1'b1;
            sync_clk_timer2_only_o <= 1'b0;
        end else begin
            clk_cpu_en_o <= state_r == SMCG_ST_RUN;
            clk_flash_en_o <= state_r == SMCG_ST_RUN || state_r == SMCG_ST_HOLD;
            clk_io_en_o <= !(m_adcq | deep);
            clk_adc_en_o <= !deep;
            clk_asy_en_o <= !(m_pdown | m_stby) && !((m_psave | m_xstby) && !timer2_async_i);
            main_osc_en_o <= !(m_pdown | (m_psave & timer2_async_i));
            timer_osc_en_o <= !(m_pdown | m_stby | ((m_psave | m_xstby) & !timer2_async_i));
            sync_clk_timer2_only_o <= (m_psave | m_xstby) && timer2_en_i && !timer2_async_i;
        end
    end

    // ********************************************************
    // Analog helpers and watchdog
    // ********************************************************
    logic adcq_entry_r;
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            adcq_entry_r <= 1'b0;
            adc_start_o <= 1'b0;
        end else begin
            // Both conversion modes share the entry marker so the start fires once
            adcq_entry_r <= m_adcq | m_idle;
            adc_start_o <= (m_adcq | m_idle) && !adcq_entry_r && adc_en_i && !cnt_busy;
        end
    end

    assign adc_keep_en_o = adc_en_i;
    assign ac_en_o = ac_en_i && (!deep || ac_uses_ref_i);
    assign bod_en_o = brownout_level_fuses_en_i && !(deep && deep_sleep_i);
    assign vref_en_o = bod_en_o | ac_en_o | adc_en_i;
    assign wdt_run_o = wdt_en_i;

    // ********************************************************
    // Pin buffers
    // ********************************************************
    logic bufs_off;
    assign bufs_off = deep;
    assign lo_buf_en_o = ~analog_pin_buffer_off_lo_i & ({NPIN{~bufs_off}} | wake_pin_mask_i);
    assign hi_buf_en_o = ~analog_pin_buffer_off_hi_i & ({NPIN{~bufs_off}} | wake_pin_mask_i);

    // ********************************************************
    // Power reduction
    // ********************************************************
    smcg_periph_gate #(.N(NPER)) u_gate (
        .reduce_i(power_reduction_bits_i),
        .clk_en_i({NPER{clk_io_en_o}}),
        .sel_i(periph_sel_i),
        .clk_en_o(periph_clk_en_o),
        .reg_acc_en_o(periph_reg_acc_en_o),
        .pins_keep_o(periph_pins_keep_o)
    );

    assign radio_rst_o = radio_reduce_i;
    assign core_run_o = state_r == SMCG_ST_RUN;
    assign reset_wake_o = sleeping && wake_rst;
    assign asleep_o = sleeping;
endmodule // smcg_sleep_ctrl

// *** dv/smcg_sleep_ctrl_properties.sv ***
`timescale 1ns/1ps
module smcg_sleep_ctrl_props
    import smcg_pkg::*;
#(
    parameter int NPER = 8,
    parameter int NPIN = 16
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic sleep_arm_bit_i,
    input wire logic [2:0] sleep_select_field_i,
    input wire logic sleep_instr_i,
    input wire logic radio_xosc_sel_i,
    input wire logic adc_en_i,
    input wire logic ac_uses_ref_i,
    input wire logic deep_sleep_i,
    input wire logic [NPER-1:0] power_reduction_bits_i,
    input wire logic radio_reduce_i,
    input wire logic [NPIN-1:0] wake_pin_mask_i,
    input wire logic core_run_o,
    input wire logic clk_cpu_en_o,
    input wire logic clk_flash_en_o,
    input wire logic clk_io_en_o,
    input wire logic clk_adc_en_o,
    input wire logic clk_asy_en_o,
    input wire logic main_osc_en_o,
    input wire logic adc_start_o,
    input wire logic adc_keep_en_o,
    input wire logic ac_en_o,
    input wire logic vref_en_o,
    input wire logic bod_en_o,
    input wire logic [NPIN-1:0] lo_buf_en_o,
    input wire logic [NPER-1:0] periph_clk_en_o,
    input wire logic [NPER-1:0] periph_reg_acc_en_o,
    input wire logic radio_rst_o,
    input wire logic asleep_o
);
    // ********************************************************
    // Sleep entry and clock domains
    // ********************************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    logic legal;
    logic deep;
    assign legal = !(sleep_select_field_i inside {SMCG_SEL_RSV4, SMCG_SEL_RSV5})
        && (sleep_select_field_i < SMCG_SEL_STBY || radio_xosc_sel_i);
    // Power-down family: both the I/O and the ADC clock are stopped
    assign deep = asleep_o && !clk_io_en_o && !clk_adc_en_o;
    a_sleep_entry: assert property (core_run_o && sleep_instr_i && sleep_arm_bit_i && legal |=> asleep_o)
        else $error("sleep not entered");
    a_rsv_refused: assert property (core_run_o && sleep_instr_i && !legal |=> !asleep_o)
        else $error("illegal code entered sleep");
    a_idle_clocks: assert property ($rose(asleep_o) && $past(sleep_select_field_i) == SMCG_SEL_IDLE
        |=> !clk_cpu_en_o && !clk_flash_en_o && clk_io_en_o && clk_adc_en_o) else $error("idle clocks wrong");
    a_adcq_clocks: assert property ($rose(asleep_o) && $past(sleep_select_field_i) == SMCG_SEL_ADCQ
        |=> !clk_cpu_en_o && !clk_io_en_o && clk_adc_en_o && clk_asy_en_o) else $error("quiet clocks wrong");
    a_pdown_clocks: assert property ($rose(asleep_o) && $past(sleep_select_field_i) == SMCG_SEL_PDOWN
        |=> !(clk_cpu_en_o | clk_flash_en_o | clk_io_en_o | clk_adc_en_o | clk_asy_en_o)) else $error("pd clocks");
    a_stby_osc: assert property ($rose(asleep_o) && $past(sleep_select_field_i) == SMCG_SEL_STBY
        |=> main_osc_en_o && !clk_io_en_o) else $error("standby oscillator stopped");
    a_adc_start: assert property ($rose(asleep_o) && $past(sleep_select_field_i) == SMCG_SEL_ADCQ && adc_en_i
        |-> ##[0:2] adc_start_o) else $error("no conversion start");
    // ********************************************************
    // Analog helpers and gating
    // ********************************************************
    a_ac_off: assert property (deep && !ac_uses_ref_i |-> !ac_en_o) else $error("comparator left on");
    a_vref_off: assert property (!bod_en_o && !ac_en_o && !adc_keep_en_o |-> !vref_en_o)
        else $error("reference on without user");
    a_bod_deep: assert property (deep && deep_sleep_i |-> !bod_en_o) else $error("brown-out on in deep sleep");
    a_buf_wake: assert property (deep |-> (lo_buf_en_o & ~wake_pin_mask_i) == '0) else $error("buffer on");
    a_prr_gate: assert property ((power_reduction_bits_i & (periph_clk_en_o | periph_reg_acc_en_o)) == '0)
        else $error("reduced peripheral active");
    a_radio_rst: assert property (radio_reduce_i |-> radio_rst_o) else $error("radio not in reset");
    c_entry: cover property ($rose(asleep_o));
    c_wake: cover property ($fell(asleep_o) ##[1:100] core_run_o);
    c_adc_start: cover property (adc_start_o);
endmodule // smcg_sleep_ctrl_props

bind smcg_sleep_ctrl smcg_sleep_ctrl_props #(.NPER(NPER), .NPIN(NPIN)) smcg_sleep_ctrl_props_inst (.*);

// *** dv/smcg_wake_src.sv ***
`timescale 1ns/1ps
// ********************************************************
// Wake source model
// ********************************************************
// A flag stays set until the core runs again, so level wakes are held long enough
module smcg_wake_src (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic fire_i,
    input wire logic [3:0] src_i,
    input wire logic core_run_i,
    output logic [10:0] flag_o
);
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            flag_o <= 11'h000;
        end else if (fire_i) begin
            flag_o <= flag_o | (11'h001 << src_i);
        end else if (core_run_i) begin
            flag_o <= 11'h000;
        end
    end
endmodule // smcg_wake_src

// *** dv/smcg_sleep_ctrl_bench.sv ***
`timescale 1ns/1ps
module smcg_sleep_ctrl_bench
    import smcg_pkg::*;
;
    // ********************************************************
    // Stimulus and wiring
    // ********************************************************
    logic clk_sys_i = 1'b0, rst_i = 1'b1, sleep_arm_bit_i = 1'b1, sleep_instr_i = 1'b0, radio_xosc_sel_i = 1'b1;
    logic core_status_word_gie_i = 1'b0, wdt_irq_i = 1'b0, twi_irq_i = 1'b0, timer2_irq_i = 1'b0;
    logic upper_ext_level_i = 1'b1, timer2_en_i = 1'b1, timer2_async_i = 1'b1, adc_en_i = 1'b1, ac_en_i = 1'b1;
    logic ac_uses_ref_i = 1'b0, brownout_level_fuses_en_i = 1'b1, deep_sleep_i = 1'b1, wdt_en_i = 1'b1;
    logic radio_reduce_i = 1'b1, fire = 1'b0;
    logic [2:0] sleep_select_field_i = 3'h0;
    logic [3:0] src = 4'h0;
    logic [15:0] clock_source_fuses_delay_i = 16'h0028;
    logic [1:0] timer2_irq_mask_i = 2'h1;
    logic [7:0] power_reduction_bits_i = 8'h0F, periph_sel_i = 8'hFF;
    logic [15:0] analog_pin_buffer_off_lo_i = 16'h0003, analog_pin_buffer_off_hi_i = 16'h0000;
    logic [15:0] wake_pin_mask_i = 16'h00FF;
    logic core_run_o, clk_cpu_en_o, clk_flash_en_o, clk_io_en_o, clk_adc_en_o, clk_asy_en_o, main_osc_en_o;
    logic timer_osc_en_o, sync_clk_timer2_only_o, adc_start_o, adc_keep_en_o, ac_en_o, vref_en_o, bod_en_o;
    logic wdt_run_o, radio_rst_o, reset_wake_o, asleep_o;
    logic [15:0] lo_buf_en_o, hi_buf_en_o;
    logic [7:0] periph_clk_en_o, periph_reg_acc_en_o, periph_pins_keep_o;
    logic [10:0] flag;
    wire pin_change_irq_i = flag[0], spm_ee_ready_irq_i = flag[1], ext_reset_i = flag[2], adc_done_irq_i = flag[3];
    wire wdt_reset_i = flag[5], bod_reset_i = flag[6], twi_addr_match_i = flag[7], symcnt_irq_i = flag[9];
    wire [1:0] timer2_event_i = {1'b0, flag[4]};
    wire [3:0] lower_ext_irqs_i = {3'h0, flag[8]};
    wire [3:0] upper_ext_irqs_i = {3'h0, flag[10]};
    int mismatches = 0, n_checks = 0, cyc = 0, starts = 0, s0, lat, d;
    int lat_tbl [8];
    logic [3:0] clk_tbl [8] = '{4'h3, 4'h1, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
    // Row: {gie and mode, source, wake expected}
    logic [11:0] rows [18] = '{12'h201, 12'h210, 12'h201, 12'h251, 12'h261, 12'h271, 12'h281, 12'h291, 12'h2A1,
        12'h230, 12'h240, 12'h201, 12'h131, 12'h111, 12'h340, 12'hB41, 12'hF41, 12'h601};

    smcg_sleep_ctrl smcg_sleep_ctrl_inst (.*);
    smcg_wake_src smcg_wake_src_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .fire_i(fire), .src_i(src),
        .core_run_i(core_run_o), .flag_o(flag));

    always #4 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        cyc++;
        if (adc_start_o === 1'b1) starts++;
        if (cyc == 20000) begin
            mismatches++;
            results();
        end
    end

    // ********************************************************
    // Tasks
    // ********************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask

    task automatic results;
        $display("Checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic nap(input logic [2:0] c);
        @(negedge clk_sys_i);
        sleep_select_field_i = c;
        sleep_instr_i = 1'b1;
        @(negedge clk_sys_i);
        sleep_instr_i = 1'b0;
        repeat (3) @(negedge clk_sys_i);
    endtask

    // Sleeps if awake, fires one wake source, waits a bounded time for the core
    task automatic tryw(input logic [11:0] r);
        int n;
        n = 0;
        core_status_word_gie_i = r[11];
        if (core_run_o === 1'b1) nap(r[10:8]);
        @(negedge clk_sys_i);
        fire = 1'b1;
        src = r[7:4];
        @(negedge clk_sys_i);
        fire = 1'b0;
        while (core_run_o !== 1'b1 && n < 100) begin
            @(negedge clk_sys_i);
            n++;
        end
        lat = n;
        chk(core_run_o, r[0]);
    endtask

    // ********************************************************
    // Main sequence
    // ********************************************************
    initial begin
        repeat (6) @(negedge clk_sys_i);
        rst_i = 1'b0;
        chk({core_run_o, clk_cpu_en_o, asleep_o}, 3'h6);
        chk(periph_clk_en_o & 8'h0F, 8'h00);
        chk(periph_reg_acc_en_o & 8'h0F, 8'h00);
        chk(periph_pins_keep_o & 8'h0F, 8'h0F);
        chk(radio_rst_o, 1'b1);
        power_reduction_bits_i = 8'h00;
        radio_reduce_i = 1'b0;
        @(negedge clk_sys_i);
        chk(periph_clk_en_o, 8'hFF);
        chk(radio_rst_o, 1'b0);
        for (int c = 0; c < 8; c++) begin
            s0 = starts;
            nap(3'(c));
            chk(asleep_o, !(c inside {4, 5}));
            if (asleep_o === 1'b1) begin
                chk({clk_cpu_en_o, clk_flash_en_o, clk_io_en_o, clk_adc_en_o}, clk_tbl[c]);
                chk({ac_en_o, bod_en_o}, c < 2 ? 2'h3 : 2'h0);
                chk(lo_buf_en_o, c < 2 ? 16'hFFFC : 16'h00FC);
                chk(hi_buf_en_o, c < 2 ? 16'hFFFF : 16'h00FF);
                chk(clk_asy_en_o, c inside {0, 1, 3, 7});
                if (c == 3) chk({timer_osc_en_o, sync_clk_timer2_only_o}, 2'h2);
                chk({adc_keep_en_o, wdt_run_o}, 2'h3);
                chk(starts - s0, c < 2);
                if (c > 1) chk(main_osc_en_o, c > 5);
                tryw({4'(c), 4'h2, 4'h1});
                lat_tbl[c] = lat;
            end
        end
        chk(lat_tbl[2] - lat_tbl[6], 35);
        chk(lat_tbl[7], lat_tbl[6]);
        chk(lat_tbl[3], lat_tbl[2]);
        tryw(12'h201);
        d = lat - lat_tbl[2];
        chk(d, 4);
        radio_xosc_sel_i = 1'b0;
        nap(SMCG_SEL_STBY);
        chk(asleep_o, 1'b0);
        radio_xosc_sel_i = 1'b1;
        foreach (rows[i]) tryw(rows[i]);
        adc_en_i = 1'b0;
        ac_en_i = 1'b0;
        brownout_level_fuses_en_i = 1'b0;
        @(negedge clk_sys_i);
        chk(vref_en_o, 1'b0);
        results();
    end
endmodule // smcg_sleep_ctrl_bench
